// *** common/nvm_seq_pkg.sv ***
/*
 * Constants, field positions and types shared by the nonvolatile memory
 * command sequencer. Assumes a 100 MHz bus clock and an APB master.
 */
// Function
// - code 0x0a erases program-array sector; index 0 code+addr[17:16], index 1 addr[15:0]
// - program-array sector: erase, then blank verify, then completion flag set
// - code 0x12 erases one eeprom sector, same parameter layout as program-array erase
// - eeprom sector: erase, then verify, then completion flag set
// - eeprom sector erase with parameter index other than 001 raises access error
// - command unavailable in current mode or invalid 18-bit address raises access error
// - eeprom word address with bit 0 set raises access error
// - eeprom erase or program on protected region raises protection violation, no change
// - verify sets verify error on any fault, uncorrectable flag on non-correctable fault
// - eeprom program with parameter index below 010 or above 101 raises access error
// - eeprom program running past end of eeprom block raises access error
// - twenty byte-wide registers occupy word indices 0x00 through 0x13, byte offsets 0x00 through 0x4c
// - any divider write sets divider-loaded bit; bit reads 0 until first write
// - program or erase launched with divider not loaded raises access error, no run
// - while completion flag is 0 no launch and parameter window writes ignored
// - program-array protect accepts only listed scenario transitions, others ignored
// - eeprom protect only adds protection: size increases, open bit only 1 to 0
// - eeprom protect open bit set means eeprom unprotected whatever the size
// - eeprom protect open bit and size load from config byte at 0x3_ff0d at reset
// - special single-chip mode and secured state inputs steer command availability
package nvm_seq_pkg;
    // register indices; byte address is four times the index
    localparam logic [4:0] IDX_DIVIDER = 5'h00;
    localparam logic [4:0] IDX_SECURITY = 5'h01;
    localparam logic [4:0] IDX_PARAM_INDEX = 5'h02;
    localparam logic [4:0] IDX_CONFIG = 5'h04;
    localparam logic [4:0] IDX_FAULT_CFG = 5'h05;
    localparam logic [4:0] IDX_STATUS = 5'h06;
    localparam logic [4:0] IDX_FAULT_STATUS = 5'h07;
    localparam logic [4:0] IDX_PPROT = 5'h08;
    localparam logic [4:0] IDX_EEPROM_PROTECT = 5'h09;
    localparam logic [4:0] IDX_WINDOW_HI = 5'h0a;
    localparam logic [4:0] IDX_WINDOW_LO = 5'h0b;
    localparam logic [4:0] IDX_LAST = 5'h13;
    // status, divider and protect register fields
    localparam int ST_COMPLETE = 7;
    localparam int ST_ACCESS_ERROR_FLAG = 5;
    localparam int ST_PVIOL = 4;
    localparam int ST_BUSY = 3;
    localparam int ST_VERR = 1;
    localparam int ST_VUNC = 0;
    localparam int DIV_LOADED = 7;
    localparam int PP_OPEN = 7;
    localparam int PP_HDIS = 5;
    localparam int PP_LDIS = 2;
    // commands
    localparam logic [7:0] CMD_PSECTOR_ERASE = 8'h0a;
    localparam logic [7:0] CMD_EE_PROGRAM = 8'h11;
    localparam logic [7:0] CMD_EE_SECTOR_ERASE = 8'h12;
    localparam logic [2:0] PIDX_ADDR = 3'h1;
    localparam logic [2:0] PIDX_PROG_MIN = 3'h2;
    localparam logic [2:0] PIDX_PROG_MAX = 3'h5;
    // address map (plain defaults)
    localparam logic [17:0] EE_BASE = 18'h00400;
    localparam logic [17:0] EE_LAST = 18'h007ff;
    localparam logic [17:0] PF_BASE = 18'h38000;
    localparam logic [17:0] PF_LAST = 18'h3ffff;
    localparam logic [17:0] EE_PROT_UNIT = 18'h00020;
    localparam logic [17:0] CFG_EEPROM_PROTECT_ADDR = 18'h3ff0d;
    // reset values
    localparam logic [7:0] RST_PPROT = 8'hff;
    localparam logic [7:0] RST_STATUS = 8'h80;
    localparam logic [7:0] RST_SECURITY = 8'hfe;
    // array operations
    localparam logic [1:0] OP_ERASE = 2'h0;
    localparam logic [1:0] OP_VERIFY = 2'h1;
    localparam logic [1:0] OP_PROGRAM = 2'h2;
    typedef enum logic [4:0] {
        S_BOOT = 5'b00001,
        S_IDLE = 5'b00010,
        S_ERASE = 5'b00100,
        S_VERIFY = 5'b01000,
        S_PROGRAM = 5'b10000
    } seq_state_t;
endpackage

// *** verilog/nvm_sector_erase_sequencer.sv ***
/*
 * Command sequencer of the nonvolatile memory controller: APB register file,
 * launch checks, sector erase/verify and eeprom program, timebase divider,
 * protection registers. Assumes the array answers each request with a
 * one-cycle done pulse and that i_cfg_eeprom_protect is stable at reset release.
 */
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module nvm_sector_erase_sequencer
    import nvm_seq_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_special_mode,
    input wire logic i_secured,
    input wire logic [7:0] i_cfg_eeprom_protect,
    output logic o_array_req,
    output logic [1:0] o_array_op,
    output logic o_array_eeprom,
    output logic [17:0] o_array_addr,
    output logic [15:0] o_array_wdata,
    input wire logic i_array_done,
    input wire logic i_array_err,
    input wire logic i_array_uncorr,
    output logic o_nvm_timebase_tick
);

    typedef struct packed {
        seq_state_t state;
        logic [7:0] divider;
        logic [2:0] pidx;
        logic [7:0] config_ctl;
        logic [1:0] fault_cfg;
        logic [7:0] status;
        logic [7:0] pprot;
        logic [7:0] eeprom_protect;
        logic [7:0][15:0] window;
        logic [7:0] rdata;
        logic req;
        logic [1:0] op;
        logic eeprom;
        logic [17:0] addr;
        logic [15:0] wdata;
        logic [2:0] word;
        logic [2:0] last_word;
        logic [5:0] tb_cnt;
        logic tick;
    } state_t;

    state_t cur_r;
    state_t cur_nxt;

    // scenario code built from the open and two disable bits
    function automatic logic [2:0] scen(input logic [7:0] v);
        scen = {v[PP_OPEN], v[PP_HDIS], v[PP_LDIS]};
    endfunction

    function automatic logic pprot_allowed(input logic [2:0] f, input logic [2:0] t);
        case (f)
            3'h0: pprot_allowed = (t <= 3'h3);
            3'h1: pprot_allowed = (t == 3'h1) || (t == 3'h3);
            3'h2: pprot_allowed = (t == 3'h2) || (t == 3'h3);
            3'h3: pprot_allowed = (t == 3'h3);
            3'h4: pprot_allowed = (t == 3'h3) || (t == 3'h4);
            3'h5: pprot_allowed = (t >= 3'h2) && (t <= 3'h5);
            3'h6: pprot_allowed = (t == 3'h1) || (t == 3'h3) || (t == 3'h4) || (t == 3'h6);
            3'h7: pprot_allowed = 1'b1;
            default: pprot_allowed = 1'b0;
        endcase
    endfunction

    // open may only fall; size may only grow, or stay while the open bit falls
    function automatic logic eeprom_protect_allowed(input logic [7:0] f, input logic [7:0] t);
        if (t[7] > f[7]) begin
            eeprom_protect_allowed = 1'b0;
        end else if (t[6:0] > f[6:0]) begin
            eeprom_protect_allowed = 1'b1;
        end else begin
            eeprom_protect_allowed = (t[6:0] == f[6:0]) && (t[7] != f[7]);
        end
    endfunction

    logic apb_access;
    logic apb_wr;
    logic apb_rd;
    logic [4:0] reg_idx;
    logic addr_ok;
    logic [7:0] wbyte;
    logic [7:0] cmd;
    logic [17:0] gaddr;
    logic ee_range;
    logic pf_range;
    logic ee_prot;
    logic mode_ok;
    logic [17:0] run_end;
    logic acc_err;
    logic prot_err;
    logic launch;

    assign apb_access = i_psel && i_penable;
    assign reg_idx = i_paddr[6:2];
    assign addr_ok = (i_paddr[31:7] == 25'h0) && (i_paddr[1:0] == 2'h0)
        && (reg_idx <= IDX_LAST);
    assign apb_wr = apb_access && i_pwrite && addr_ok;
    assign apb_rd = i_psel && !i_penable && !i_pwrite && addr_ok;
    assign wbyte = i_pwdata[7:0];

    assign cmd = cur_r.window[0][15:8];
    assign gaddr = {cur_r.window[0][1:0], cur_r.window[1]};
    assign ee_range = (gaddr >= EE_BASE) && (gaddr <= EE_LAST);
    assign pf_range = (gaddr >= PF_BASE) && (gaddr <= PF_LAST);
    // the region protected grows upward from the eeprom base, one unit per size step
    assign ee_prot = !cur_r.eeprom_protect[7]
        && ((gaddr - EE_BASE) < (18'({11'h0, cur_r.eeprom_protect[6:0]}) + 18'h1) * EE_PROT_UNIT);
    // secured special single-chip mode drops both erase and program commands
    assign mode_ok = !(i_special_mode && i_secured);
    // each extra word past index 2 adds two bytes to the run
    assign run_end = gaddr + 18'({cur_r.pidx - PIDX_PROG_MIN, 1'b0});

    assign launch = apb_wr && (reg_idx == IDX_STATUS) && wbyte[ST_COMPLETE]
        && cur_r.status[ST_COMPLETE] && !cur_r.status[ST_ACCESS_ERROR_FLAG]
        && !cur_r.status[ST_PVIOL];

    always_comb begin
        acc_err = !cur_r.divider[DIV_LOADED] || !mode_ok;
        prot_err = 1'b0;
        case (cmd)
            CMD_PSECTOR_ERASE: begin
                acc_err = acc_err || (cur_r.pidx != PIDX_ADDR) || !pf_range;
                prot_err = !cur_r.pprot[PP_OPEN];
            end
            CMD_EE_SECTOR_ERASE: begin
                acc_err = acc_err || (cur_r.pidx != PIDX_ADDR)
                    || !ee_range || gaddr[0];
                prot_err = ee_prot;
            end
            CMD_EE_PROGRAM: begin
                acc_err = acc_err || (cur_r.pidx < PIDX_PROG_MIN)
                    || (cur_r.pidx > PIDX_PROG_MAX)
                    || !ee_range || gaddr[0]
                    || (run_end > EE_LAST - 18'h1);
                prot_err = ee_prot;
            end
            default: acc_err = 1'b1;
        endcase
    end

    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.rdata = 8'h00;
        cur_nxt.tick = 1'b0;
        // timebase: one tick every divider+1 bus cycles
        if (cur_r.tb_cnt >= cur_r.divider[5:0]) begin
            cur_nxt.tb_cnt = 6'h0;
            cur_nxt.tick = cur_r.divider[DIV_LOADED];
        end else begin
            cur_nxt.tb_cnt = cur_r.tb_cnt + 6'h1;
        end
        if (apb_rd) begin
            case (reg_idx)
                IDX_DIVIDER: cur_nxt.rdata = cur_r.divider;
                IDX_SECURITY: cur_nxt.rdata = RST_SECURITY;
                IDX_PARAM_INDEX: cur_nxt.rdata = {5'h0, cur_r.pidx};
                IDX_CONFIG: cur_nxt.rdata = cur_r.config_ctl;
                IDX_FAULT_CFG: cur_nxt.rdata = {6'h0, cur_r.fault_cfg};
                IDX_STATUS: cur_nxt.rdata = cur_r.status;
                IDX_PPROT: cur_nxt.rdata = cur_r.pprot;
                IDX_EEPROM_PROTECT: cur_nxt.rdata = cur_r.eeprom_protect;
                IDX_WINDOW_HI: cur_nxt.rdata = cur_r.window[cur_r.pidx][15:8];
                IDX_WINDOW_LO: cur_nxt.rdata = cur_r.window[cur_r.pidx][7:0];
                default: cur_nxt.rdata = 8'h00;
            endcase
        end
        // the other registers still take writes while busy; only window writes are dropped
        if (apb_wr) begin
            case (reg_idx)
                IDX_DIVIDER: cur_nxt.divider = {1'b1, 1'b0, wbyte[5:0]};
                IDX_PARAM_INDEX: cur_nxt.pidx = wbyte[2:0];
                IDX_CONFIG: cur_nxt.config_ctl = wbyte & 8'h93;
                IDX_FAULT_CFG: cur_nxt.fault_cfg = wbyte[1:0];
                IDX_STATUS: begin
                    if (wbyte[ST_ACCESS_ERROR_FLAG]) begin
                        cur_nxt.status[ST_ACCESS_ERROR_FLAG] = 1'b0;
                    end
                    if (wbyte[ST_PVIOL]) begin
                        cur_nxt.status[ST_PVIOL] = 1'b0;
                    end
                end
                IDX_PPROT: begin
                    if (pprot_allowed(scen(cur_r.pprot), scen(wbyte))) begin
                        cur_nxt.pprot = wbyte;
                    end
                end
                IDX_EEPROM_PROTECT: begin
                    if (eeprom_protect_allowed(cur_r.eeprom_protect, wbyte)) begin
                        cur_nxt.eeprom_protect = wbyte;
                    end
                end
                IDX_WINDOW_HI: begin
                    if (cur_r.status[ST_COMPLETE]) begin
                        cur_nxt.window[cur_r.pidx][15:8] = wbyte;
                    end
                end
                IDX_WINDOW_LO: begin
                    if (cur_r.status[ST_COMPLETE]) begin
                        cur_nxt.window[cur_r.pidx][7:0] = wbyte;
                    end
                end
                default: cur_nxt.rdata = cur_nxt.rdata;
            endcase
        end
        case (cur_r.state)
            S_BOOT: begin
                // config byte at CFG_EEPROM_PROTECT_ADDR arrives on i_cfg_eeprom_protect
                cur_nxt.eeprom_protect = i_cfg_eeprom_protect;
                cur_nxt.state = S_IDLE;
            end
            S_IDLE: begin
                if (launch) begin
                    cur_nxt.status[ST_VERR] = 1'b0;
                    cur_nxt.status[ST_VUNC] = 1'b0;
                    if (acc_err) begin
                        cur_nxt.status[ST_ACCESS_ERROR_FLAG] = 1'b1;
                    end else if (prot_err) begin
                        cur_nxt.status[ST_PVIOL] = 1'b1;
                    end else begin
                        cur_nxt.status[ST_COMPLETE] = 1'b0;
                        cur_nxt.status[ST_BUSY] = 1'b1;
                        cur_nxt.req = 1'b1;
                        cur_nxt.addr = gaddr;
                        cur_nxt.eeprom = (cmd != CMD_PSECTOR_ERASE);
                        cur_nxt.word = PIDX_PROG_MIN;
                        cur_nxt.last_word = cur_r.pidx;
                        cur_nxt.wdata = cur_r.window[PIDX_PROG_MIN];
                        if (cmd == CMD_EE_PROGRAM) begin
                            cur_nxt.op = OP_PROGRAM;
                            cur_nxt.state = S_PROGRAM;
                        end else begin
                            cur_nxt.op = OP_ERASE;
                            cur_nxt.state = S_ERASE;
                        end
                    end
                end
            end
            S_ERASE: begin
                if (i_array_done) begin
                    cur_nxt.op = OP_VERIFY;
                    cur_nxt.state = S_VERIFY;
                end
            end
            S_VERIFY: begin
                if (i_array_done) begin
                    cur_nxt.status[ST_VERR] = i_array_err || i_array_uncorr;
                    cur_nxt.status[ST_VUNC] = i_array_uncorr;
                    cur_nxt.status[ST_COMPLETE] = 1'b1;
                    cur_nxt.status[ST_BUSY] = 1'b0;
                    cur_nxt.req = 1'b0;
                    cur_nxt.state = S_IDLE;
                end
            end
            S_PROGRAM: begin
                if (i_array_done) begin
                    cur_nxt.status[ST_VERR] = cur_r.status[ST_VERR] || i_array_err
                        || i_array_uncorr;
                    cur_nxt.status[ST_VUNC] = cur_r.status[ST_VUNC] || i_array_uncorr;
                    if (cur_r.word == cur_r.last_word) begin
                        cur_nxt.status[ST_COMPLETE] = 1'b1;
                        cur_nxt.status[ST_BUSY] = 1'b0;
                        cur_nxt.req = 1'b0;
                        cur_nxt.state = S_IDLE;
                    end else begin
                        cur_nxt.word = cur_r.word + 3'h1;
                        cur_nxt.addr = cur_r.addr + 18'h2;
                        cur_nxt.wdata = cur_r.window[cur_r.word + 3'h1];
                    end
                end
            end
            default: cur_nxt.state = S_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cur_r <= '0;
            cur_r.state <= S_BOOT;
            cur_r.status <= RST_STATUS;
            cur_r.pprot <= RST_PPROT;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign o_prdata = {24'h0, cur_r.rdata};
    // zero wait states: reads are captured in setup, writes land at the access edge
    assign o_pready = 1'b1;
    assign o_pslverr = apb_access && !addr_ok;
    assign o_array_req = cur_r.req;
    assign o_array_op = cur_r.op;
    assign o_array_eeprom = cur_r.eeprom;
    assign o_array_addr = cur_r.addr;
    assign o_array_wdata = cur_r.wdata;
    assign o_nvm_timebase_tick = cur_r.tick;

endmodule
`default_nettype wire

// *** bench/nvm_array_model.sv ***
/* Behavioural model of the flash and eeprom arrays behind the sequencer.
   Assumes the sequencer holds its request level until the done pulse. */
`timescale 1ns/10ps
`default_nettype none
module nvm_array_model
    import nvm_seq_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_req,
    input wire logic [1:0] i_op,
    input wire logic [7:0] i_delay,
    input wire logic [1:0] i_fault,
    output logic o_done,
    output logic o_err,
    output logic o_uncorr
);
    logic [7:0] cnt_r;
    logic busy;
    assign busy = i_req && !o_done;
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_r <= 8'h00;
            o_done <= 1'b0;
        end else begin
            o_done <= busy && cnt_r == i_delay;
            cnt_r <= (busy && cnt_r != i_delay) ? cnt_r + 8'h01 : 8'h00;
        end
    end
    // fault lines only mean something with done; otherwise they toggle
    assign o_err = o_done ? (i_fault[1] && i_op == OP_VERIFY) : cnt_r[0];
    assign o_uncorr = o_done ? (i_fault[0] && i_op == OP_VERIFY) : ~cnt_r[0];
endmodule
`default_nettype wire

// *** bench/nvm_seq_checker.sv ***
/* Port checker of the nvm command sequencer.
   Bound to the sequencer; one clock, asynchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module nvm_seq_checker
    import nvm_seq_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pslverr,
    input wire logic i_special_mode,
    input wire logic i_secured,
    input wire logic o_array_req,
    input wire logic [1:0] o_array_op,
    input wire logic o_array_eeprom,
    input wire logic [17:0] o_array_addr,
    input wire logic i_array_done,
    input wire logic o_nvm_timebase_tick
);
    logic div_seen_r;
    // divider-loaded state is not a port, so it is rebuilt from bus writes
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            div_seen_r <= 1'b0;
        end else if (i_psel && i_penable && i_pwrite && i_paddr[6:2] == IDX_DIVIDER) begin
            div_seen_r <= 1'b1;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    a_start_not_verify: assert property ($rose(o_array_req) |-> o_array_op != OP_VERIFY)
        else $error("run started with verify");
    a_erase_then_verify: assert property (o_array_req && o_array_op == OP_ERASE
        && i_array_done |=> o_array_req && o_array_op == OP_VERIFY)
        else $error("no verify after erase");
    a_verify_ends_run: assert property (o_array_req && o_array_op == OP_VERIFY
        && i_array_done |=> !o_array_req) else $error("run did not end after verify");
    a_no_run_unloaded: assert property ($rose(o_array_req) |-> div_seen_r)
        else $error("run without divider loaded");
    a_mode_blocks_run: assert property ($rose(o_array_req) |->
        !$past(i_special_mode && i_secured)) else $error("run in blocked mode");
    a_launch_cause: assert property ($rose(o_array_req) |-> $past(i_psel && i_penable
        && i_pwrite && i_paddr[6:2] == IDX_STATUS && i_pwdata[7])) else $error("run w/o launch");
    a_addr_valid: assert property ($rose(o_array_req) |-> (o_array_eeprom ?
        (!o_array_addr[0] && o_array_addr >= EE_BASE && o_array_addr <= EE_LAST)
        : o_array_addr >= PF_BASE)) else $error("run on bad address");
    a_run_steady: assert property (o_array_req && !i_array_done |=> o_array_req
        && $stable(o_array_op) && $stable(o_array_addr)) else $error("request changed mid op");
    a_bad_index_err: assert property (i_psel && i_penable && i_paddr[31:7] == 0
        && i_paddr[1:0] == 0 |-> o_pslverr == (i_paddr[6:2] > IDX_LAST)) else $error("pslverr");
    a_tick_loaded: assert property (o_nvm_timebase_tick |-> div_seen_r)
        else $error("tick before divider load");
endmodule
bind nvm_sector_erase_sequencer nvm_seq_checker u_chk (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pslverr(o_pslverr), .i_special_mode(i_special_mode),
    .i_secured(i_secured), .o_array_req(o_array_req), .o_array_op(o_array_op),
    .o_array_eeprom(o_array_eeprom), .o_array_addr(o_array_addr),
    .i_array_done(i_array_done), .o_nvm_timebase_tick(o_nvm_timebase_tick));
`default_nettype wire

// *** bench/nvm_sector_erase_sequencer_tb.sv ***
/* Self-checking bench of the nvm command sequencer over APB.
   Assumes the array model and the bound checker are compiled alongside. */
`timescale 1ns/10ps
`default_nettype none
module nvm_sector_erase_sequencer_tb;
    import nvm_seq_pkg::*;
    logic i_clock = 0, i_rstn = 0, psel = 0, penable = 0, pwrite = 0, special = 0, secured = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic pready, pslverr, req, eeprom, done, err, unc, tick;
    logic [1:0] op, fault = 0;
    logic [17:0] aaddr;
    logic [15:0] wdata;
    logic [7:0] dly = 0, cfg = 8'h82;
    int bad_count = 0, num_checks = 0;
    always #5 i_clock = ~i_clock;
    nvm_sector_erase_sequencer dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_special_mode(special),
        .i_secured(secured), .i_cfg_eeprom_protect(cfg), .o_array_req(req), .o_array_op(op),
        .o_array_eeprom(eeprom), .o_array_addr(aaddr), .o_array_wdata(wdata),
        .i_array_done(done), .i_array_err(err), .i_array_uncorr(unc), .o_nvm_timebase_tick(tick));
    nvm_array_model model (.i_clock(i_clock), .i_rstn(i_rstn), .i_req(req), .i_op(op),
        .i_delay(dly), .i_fault(fault), .o_done(done), .o_err(err), .o_uncorr(unc));
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] i, input logic [7:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge i_clock);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {25'h0, i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge i_clock);
        penable <= 1;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 50) begin
            bad_count++;
            summarize();
        end
    endtask
    task automatic wr(input logic [4:0] i, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        bus(1, i, d, r, e);
    endtask
    task automatic rdchk(input logic [4:0] i, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        bus(0, i, 8'h00, r, e);
        check(r, {24'h0, x});
    endtask
    task automatic poll(output logic [7:0] st);
        logic [31:0] r;
        logic e;
        int n;
        n = 0;
        do begin
            bus(0, IDX_STATUS, 8'h00, r, e);
            n++;
        end while (r[ST_COMPLETE] !== 1'b1 && n < 100);
        st = r[7:0];
        if (n >= 100) begin
            bad_count++;
            summarize();
        end
    endtask
    task automatic load(input logic [7:0] c, input logic [2:0] pi, input logic [17:0] a);
        wr(IDX_PARAM_INDEX, 8'h00);
        wr(IDX_WINDOW_HI, c);
        wr(IDX_WINDOW_LO, {6'h0, a[17:16]});
        wr(IDX_PARAM_INDEX, 8'h01);
        wr(IDX_WINDOW_HI, a[15:8]);
        wr(IDX_WINDOW_LO, a[7:0]);
        wr(IDX_PARAM_INDEX, {5'h0, pi});
    endtask
    task automatic run(input logic [7:0] c, input logic [2:0] pi, input logic [17:0] a,
        input logic m, input logic [7:0] x);
        logic [7:0] st;
        load(c, pi, a);
        special <= m;
        secured <= m;
        wr(IDX_STATUS, 8'h80);
        special <= 0;
        secured <= 0;
        poll(st);
        check({24'h0, st}, {24'h0, x});
        wr(IDX_STATUS, 8'h30);
    endtask
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rdchk(IDX_STATUS, 8'h80);
        rdchk(IDX_PPROT, 8'hff);
        rdchk(IDX_EEPROM_PROTECT, 8'h82);
        rdchk(IDX_DIVIDER, 8'h00);
        rdchk(5'h0c, 8'h00);
        rdchk(IDX_LAST, 8'h00);
        bus(0, 5'h14, 8'h00, r, e);
        check({31'h0, e}, 32'h1);
        $display("reset values done");
    endtask
    task automatic t_divider();
        int n;
        run(CMD_PSECTOR_ERASE, 1, 18'h3a000, 0, 8'ha0);
        wr(IDX_DIVIDER, 8'h03);
        rdchk(IDX_DIVIDER, 8'h83);
        n = 0;
        repeat (40) begin
            @(posedge i_clock);
            n += tick;
        end
        check(n, 10);
        $display("divider load done");
    endtask
    task automatic t_perase();
        logic [7:0] st;
        dly <= 20;
        fault <= 2'b11;
        load(CMD_PSECTOR_ERASE, 1, 18'h3a000);
        wr(IDX_STATUS, 8'h80);
        rdchk(IDX_STATUS, 8'h08);
        check({13'h0, eeprom, aaddr}, {14'h0, 18'h3a000});
        wr(IDX_WINDOW_HI, 8'h55);
        wr(IDX_STATUS, 8'h80);
        poll(st);
        check({24'h0, st}, 32'h83);
        rdchk(IDX_WINDOW_HI, 8'ha0);
        check({31'h0, req}, 32'h0);
        fault <= 2'b00;
        dly <= 0;
        $display("program-array erase done");
    endtask
    task automatic t_table();
        run(CMD_EE_SECTOR_ERASE, 0, 18'h00400, 0, 8'ha0);
        run(CMD_EE_SECTOR_ERASE, 1, 18'h00401, 0, 8'ha0);
        run(CMD_EE_SECTOR_ERASE, 1, 18'h01000, 0, 8'ha0);
        run(CMD_EE_SECTOR_ERASE, 1, 18'h00400, 1, 8'ha0);
        run(CMD_EE_PROGRAM, 1, 18'h00400, 0, 8'ha0);
        run(CMD_EE_PROGRAM, 6, 18'h00400, 0, 8'ha0);
        run(CMD_EE_PROGRAM, 3, 18'h007fe, 0, 8'ha0);
        wr(IDX_PARAM_INDEX, 8'h02);
        wr(IDX_WINDOW_HI, 8'h5a);
        wr(IDX_WINDOW_LO, 8'hc3);
        run(CMD_EE_PROGRAM, 2, 18'h007fe, 0, 8'h80);
        check({16'h0, wdata}, 32'h5ac3);
        check({13'h0, eeprom, aaddr}, {14'h1, 18'h007fe});
        run(CMD_EE_SECTOR_ERASE, 1, 18'h00402, 0, 8'h80);
        check({13'h0, eeprom, aaddr}, {14'h1, 18'h00402});
        $display("launch checks done");
    endtask
    task automatic t_protect();
        wr(IDX_EEPROM_PROTECT, 8'h02);
        rdchk(IDX_EEPROM_PROTECT, 8'h02);
        wr(IDX_EEPROM_PROTECT, 8'h81);
        rdchk(IDX_EEPROM_PROTECT, 8'h02);
        run(CMD_EE_SECTOR_ERASE, 1, 18'h0045e, 0, 8'h90);
        run(CMD_EE_SECTOR_ERASE, 1, 18'h00460, 0, 8'h80);
        wr(IDX_PPROT, 8'h7f);
        rdchk(IDX_PPROT, 8'h7f);
        wr(IDX_PPROT, 8'hff);
        rdchk(IDX_PPROT, 8'h7f);
        run(CMD_PSECTOR_ERASE, 1, 18'h3a000, 0, 8'h90);
        $display("protection done");
    endtask
    task automatic t_reboot();
        cfg <= 8'h05;
        i_rstn <= 0;
        repeat (2) @(posedge i_clock);
        i_rstn <= 1;
        repeat (2) @(posedge i_clock);
        rdchk(IDX_EEPROM_PROTECT, 8'h05);
        rdchk(IDX_DIVIDER, 8'h00);
        rdchk(IDX_STATUS, 8'h80);
        run(CMD_PSECTOR_ERASE, 1, 18'h3a000, 0, 8'ha0);
        $display("second reset done");
    endtask
    initial begin
        #900000;
        bad_count++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge i_clock);
        i_rstn <= 1;
        repeat (2) @(posedge i_clock);
        t_reset();
        t_divider();
        t_perase();
        t_table();
        t_protect();
        t_reboot();
        summarize();
    end
endmodule
`default_nettype wire
